// ==== vvc_pkg.sv ====
// Package for the output and input voltage configuration command bank.
// Assumes a command-level port from the bus engine: code, data, strobes.
package vvc_pkg;
    // Command codes
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
    localparam logic [7:0] CMD_VOUT_FORMAT  = 8'h20;
    localparam logic [7:0] CMD_VOUT_TARGET  = 8'h21;
    localparam logic [7:0] CMD_VOUT_CEILING = 8'h24;
    localparam logic [7:0] CMD_MARGIN_HIGH  = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW   = 8'h26;
    localparam logic [7:0] CMD_SLEW_RATE    = 8'h27;
    localparam logic [7:0] CMD_LOOP_SCALE   = 8'h29;
    localparam logic [7:0] CMD_SW_FREQ      = 8'h33;
    localparam logic [7:0] CMD_VIN_ON       = 8'h35;

    // Fixed values and reset defaults
    localparam logic [7:0]  VOUT_FORMAT_VAL  = 8'h17;
    localparam logic [15:0] VOUT_MANT_MIN    = 16'h0100;
    localparam logic [15:0] VOUT_MANT_MAX    = 16'h0B00;
    localparam logic [15:0] CEIL_MANT_MAX    = 16'h0B01;
    localparam logic [15:0] CEILING_RST      = 16'h0B00;
    localparam logic [15:0] MARGIN_HIGH_RST  = 16'h06CD;
    localparam logic [15:0] MARGIN_LOW_RST   = 16'h0667;
    localparam logic [15:0] TARGET_RST       = 16'h0200;
    localparam logic [15:0] SLEW_RST         = 16'hD00D;
    localparam logic [15:0] LOOP_SCALE_RST   = 16'hF001;
    localparam logic [15:0] SW_FREQ_RST      = 16'h092C;
    localparam logic [15:0] VIN_ON_RST       = 16'hF80C;
    localparam logic [15:0] VIN_ON_MIN       = 16'hF806;
    localparam logic [15:0] VIN_ON_MAX       = 16'hF815;
    localparam logic [7:0]  ALERT_MASK_RST   = 8'h00;
    localparam int          MODE_PIN_BIT     = 0;

    // Margin state from the operation command
    typedef enum logic [1:0] {
        MARGIN_OFF,
        MARGIN_LOW,
        MARGIN_HIGH
    } vvc_margin_t;

    // Command request from the bus engine
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] data;
    } vvc_cmd_t;
endpackage : vvc_pkg

// ==== vvc_bank.sv ====
// Configuration command bank: stores, checks and reads back settings.
// Assumes the bus engine presents whole decoded commands, one per strobe.
//
// Contract
// RQ1: Set alert mask bit blocks the same-position status bit from raising alert.
// RQ2: Reading output voltage format returns 0x17.
// RQ3: Any write to output voltage format is rejected with invalid data fault.
// RQ4: Output voltage values are 16-bit mantissa, exponent -9.
// RQ5: Target accepted only for mantissa 256..2816, else fault.
// RQ6: Vendor mode bit 0 low makes select pin give default target.
// RQ7: Ceiling limits every commanded target; default 5.5 V.
// RQ8: Ceiling accepted only for mantissa 256..2817, else fault.
// RQ9: Active target follows margin high, low or nominal selection.
// RQ10: Margin high not above margin low faults; default 3.4 V.
// RQ11: Margin low not below margin high faults; default 3.2 V.
// RQ12: Slew rate applies to target and margin changes, not on/off.
// RQ13: Slew rate accepts D00D, D07D, D0BB, D258 only; default D00D.
// RQ14: Loop scaling accepts F001, F002, F004 only.
// RQ15: Switching frequency accepts listed codes 0864..0B84; default 092C.
// RQ16: Input turn-on accepts F806..F815; default F80C.
// RQ17: Input turn-on not above stored turn-off faults.
// RQ18: Input never reaching turn-on after bias enable raises undervoltage fault.
// RQ19: Settings are exposed for copying to nonvolatile storage.
// RQ20: Host picks loop scaling from output range.
// RQ21: Any unlisted data value faults.
// RQ22: Rejected write keeps stored value and records the fault.
`timescale 1ns/100ps
module vvc_bank #(
    parameter int UV_WAIT_CYCLES = 200000
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               wrStrobe,
    input  wire logic               rdStrobe,
    input  wire vvc_pkg::vvc_cmd_t  cmdIn,
    output logic [15:0]             rdData,
    output logic                    rdValid,
    output logic                    cmdKnown,
    output logic                    invalidDataFault,
    input  wire logic               faultClear,
    input  wire logic [7:0]         statusIn,
    output logic                    alertRequest,
    input  wire logic [7:0]         vendorModeSetting,
    input  wire logic [15:0]        voltageSelectPin,
    input  wire logic               loadDefaults,
    input  wire vvc_pkg::vvc_margin_t marginSel,
    input  wire logic               outputOn,
    input  wire logic [15:0]        vinOffThreshold,
    input  wire logic               biasEnabled,
    input  wire logic               vinAboveOn,
    output logic                    vinUvFault,
    output logic [15:0]             activeTarget,
    output logic                    slewApply,
    output logic [15:0]             slewRate,
    output logic [15:0]             loopScale,
    output logic [15:0]             switchFreq,
    output logic [15:0]             vinOnThreshold,
    output logic [15:0]             storeTarget,
    output logic [15:0]             storeCeiling,
    output logic [15:0]             storeMarginHigh,
    output logic [15:0]             storeMarginLow,
    output logic [7:0]              alertMask
);
    import vvc_pkg::*;

    // Refuse a watchdog span that the counter cannot serve
    if (UV_WAIT_CYCLES < 1) begin : g_badWait
        $error("UV_WAIT_CYCLES must be at least one");
    end

    // Mantissa window test shared by the target, ceiling and margin commands
    function automatic logic inRange(input logic [15:0] v, input logic [15:0] hi);
        inRange = (v >= VOUT_MANT_MIN) && (v <= hi);
    endfunction : inRange

    // Legal switching frequency codes
    function automatic logic freqLegal(input logic [15:0] v);
        case (v)
            16'h0864,
            16'h087D,
            16'h0896,
            16'h08AF,
            16'h08C8,
            16'h08E1,
            16'h08FA,
            16'h0913,
            16'h092C,
            16'h0945,
            16'h095E,
            16'h0977,
            16'h0990,
            16'h09A9,
            16'h09C2,
            16'h09DB,
            16'h09F4,
            16'h0A0D,
            16'h0A26,
            16'h0A3F,
            16'h0A58,
            16'h0A8A,
            16'h0ABC,
            16'h0AEE,
            16'h0B20,
            16'h0B52,
            16'h0B84: freqLegal = 1'b1; // RQ15
            default: freqLegal = 1'b0;
        endcase
    endfunction : freqLegal

    // Legal slew codes; the exponent is fixed, so whole words compare
    function automatic logic slewLegal(input logic [15:0] v);
        case (v)
            16'hD00D,
            16'hD07D,
            16'hD0BB,
            16'hD258: slewLegal = 1'b1; // RQ13
            default:  slewLegal = 1'b0;
        endcase
    endfunction : slewLegal

    // Legal loop scaling codes, gains of a quarter, a half and one
    function automatic logic loopLegal(input logic [15:0] v);
        case (v)
            16'hF001,
            16'hF002,
            16'hF004: loopLegal = 1'b1; // RQ14
            default:  loopLegal = 1'b0;
        endcase
    endfunction : loopLegal

    logic [7:0]  alertMask_reg;
    logic [15:0] target_reg;
    logic [15:0] ceiling_reg;
    logic [15:0] marginHigh_reg;
    logic [15:0] marginLow_reg;
    logic [15:0] slew_reg;
    logic [15:0] loop_reg;
    logic [15:0] freq_reg;
    logic [15:0] vinOn_reg;
    logic        fault_reg;
    logic        writeOk;
    logic        writeKnown;
    logic [15:0] d;

    assign d = cmdIn.data;

    // Legality check per command; unknown codes are not ours
    always_comb begin
        writeOk    = 1'b0;
        writeKnown = 1'b1;
        case (cmdIn.code)
            CMD_ALERT_MASK:   writeOk = (d[15:8] == 8'h00);
            CMD_VOUT_FORMAT:  writeOk = 1'b0; // RQ3
            CMD_VOUT_TARGET:  writeOk = inRange(d, VOUT_MANT_MAX); // RQ5 RQ4
            CMD_VOUT_CEILING: writeOk = inRange(d, CEIL_MANT_MAX); // RQ8
            CMD_MARGIN_HIGH:  writeOk = inRange(d, VOUT_MANT_MAX) && (d > marginLow_reg); // RQ10
            CMD_MARGIN_LOW:   writeOk = inRange(d, VOUT_MANT_MAX) && (d < marginHigh_reg); // RQ11
            CMD_SLEW_RATE:    writeOk = slewLegal(d); // RQ13
            CMD_LOOP_SCALE:   writeOk = loopLegal(d); // RQ14
            CMD_SW_FREQ:      writeOk = freqLegal(d); // RQ15
            CMD_VIN_ON:       writeOk = (d >= VIN_ON_MIN) && (d <= VIN_ON_MAX) &&
                                        (d > vinOffThreshold); // RQ16 RQ17
            default: begin
                writeKnown = 1'b0;
            end
        endcase
    end

    assign cmdKnown = writeKnown;

    // One write enable; a rejected write leaves every setting register untouched
    logic wrAccept;
    assign wrAccept = wrStrobe && writeOk && !loadDefaults; // RQ21 RQ22

    // Alert mask byte; only the low byte carries meaning
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alertMask_reg <= ALERT_MASK_RST;
        end else if (wrAccept && (cmdIn.code == CMD_ALERT_MASK)) begin
            alertMask_reg <= d[7:0];
        end
    end

    // Nominal target; pin strap is sampled on the load pulse when mode bit 0 is low, not at reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_reg <= TARGET_RST;
        end else if (loadDefaults && !vendorModeSetting[MODE_PIN_BIT]) begin
            target_reg <= voltageSelectPin; // RQ6
        end else if (wrAccept && (cmdIn.code == CMD_VOUT_TARGET)) begin
            target_reg <= d;
        end
    end

    // Ceiling on every commanded target
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ceiling_reg <= CEILING_RST; // RQ7
        end else if (wrAccept && (cmdIn.code == CMD_VOUT_CEILING)) begin
            ceiling_reg <= d;
        end
    end

    // Margin high setpoint
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            marginHigh_reg <= MARGIN_HIGH_RST;
        end else if (wrAccept && (cmdIn.code == CMD_MARGIN_HIGH)) begin
            marginHigh_reg <= d;
        end
    end

    // Margin low setpoint
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            marginLow_reg <= MARGIN_LOW_RST;
        end else if (wrAccept && (cmdIn.code == CMD_MARGIN_LOW)) begin
            marginLow_reg <= d;
        end
    end

    // Transition rate code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slew_reg <= SLEW_RST;
        end else if (wrAccept && (cmdIn.code == CMD_SLEW_RATE)) begin
            slew_reg <= d;
        end
    end

    // Loop scaling code; the host picks it from the output range
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_reg <= LOOP_SCALE_RST;
        end else if (wrAccept && (cmdIn.code == CMD_LOOP_SCALE)) begin
            loop_reg <= d;
        end
    end

    // Switching frequency code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_reg <= SW_FREQ_RST;
        end else if (wrAccept && (cmdIn.code == CMD_SW_FREQ)) begin
            freq_reg <= d;
        end
    end

    // Input turn-on threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vinOn_reg <= VIN_ON_RST;
        end else if (wrAccept && (cmdIn.code == CMD_VIN_ON)) begin
            vinOn_reg <= d;
        end
    end

    // Sticky invalid data flag; a new fault wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_reg <= 1'b0;
        end else if (wrStrobe && writeKnown && !writeOk) begin
            fault_reg <= 1'b1; // RQ22 RQ21
        end else if (faultClear) begin
            fault_reg <= 1'b0;
        end
    end

    assign invalidDataFault = fault_reg;

    // Alert gating by mask, bit for bit
    assign alertRequest = |(statusIn & ~alertMask_reg); // RQ1
    assign alertMask    = alertMask_reg;

    // Read answer flag, one cycle after the strobe, for our own codes only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStrobe && writeKnown;
        end
    end

    // Read data held until the next read, so a slow host still finds it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else if (rdStrobe) begin
            case (cmdIn.code)
                CMD_ALERT_MASK:   rdData <= {8'h00, alertMask_reg};
                CMD_VOUT_FORMAT:  rdData <= {8'h00, VOUT_FORMAT_VAL}; // RQ2
                CMD_VOUT_TARGET:  rdData <= target_reg;
                CMD_VOUT_CEILING: rdData <= ceiling_reg;
                CMD_MARGIN_HIGH:  rdData <= marginHigh_reg;
                CMD_MARGIN_LOW:   rdData <= marginLow_reg;
                CMD_SLEW_RATE:    rdData <= slew_reg;
                CMD_LOOP_SCALE:   rdData <= loop_reg;
                CMD_SW_FREQ:      rdData <= freq_reg;
                CMD_VIN_ON:       rdData <= vinOn_reg;
                default:          rdData <= 16'h0000;
            endcase
        end
    end

    // Setpoint selection then clamp by ceiling
    logic [15:0] selTarget;
    logic [15:0] prevTarget_reg;
    always_comb begin
        case (marginSel)
            MARGIN_HIGH: selTarget = marginHigh_reg; // RQ9
            MARGIN_LOW:  selTarget = marginLow_reg;
            default:     selTarget = target_reg;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            activeTarget <= CEILING_RST;
        end else begin
            activeTarget <= (selTarget > ceiling_reg) ? ceiling_reg : selTarget; // RQ7
        end
    end

    // Last active target; resets like activeTarget so reset shows no false change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevTarget_reg <= CEILING_RST;
        end else begin
            prevTarget_reg <= activeTarget;
        end
    end

    // Slew applies only to changes while the output is already on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slewApply <= 1'b0;
        end else begin
            slewApply <= outputOn && (prevTarget_reg != activeTarget); // RQ12
        end
    end

    // Undervoltage watchdog after bias comes up; count is long so it is a parameter
    logic [31:0] uvCount_reg;
    logic        uvExpired;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uvCount_reg <= 32'h0;
        end else if (!biasEnabled || vinAboveOn) begin
            uvCount_reg <= 32'h0;
        end else if (!uvExpired) begin
            uvCount_reg <= uvCount_reg + 32'h1;
        end
    end

    // Span reached; the counter stops here so it cannot wrap
    assign uvExpired = (uvCount_reg >= 32'(UV_WAIT_CYCLES));

    // Fault stays until reset, even if the input recovers later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vinUvFault <= 1'b0;
        end else if (biasEnabled && !vinAboveOn && uvExpired) begin
            vinUvFault <= 1'b1; // RQ18
        end
    end

    // Settings exposed for the store path
    assign slewRate        = slew_reg;
    assign loopScale       = loop_reg;
    assign switchFreq      = freq_reg;
    assign vinOnThreshold  = vinOn_reg;
    assign storeTarget     = target_reg; // RQ19
    assign storeCeiling    = ceiling_reg;
    assign storeMarginHigh = marginHigh_reg;
    assign storeMarginLow  = marginLow_reg;
endmodule : vvc_bank

// ==== vvc_bank_props.sv ====
// Checker for the command bank, bound to its top module.
// Assumes one clock domain and the bank's own port names.
`timescale 1ns/100ps
module vvc_bank_props (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 wrStrobe,
    input wire logic                 rdStrobe,
    input wire vvc_pkg::vvc_cmd_t    cmdIn,
    input wire logic [15:0]          rdData,
    input wire logic                 rdValid,
    input wire logic                 cmdKnown,
    input wire logic                 loadDefaults,
    input wire logic                 invalidDataFault,
    input wire logic [7:0]           statusIn,
    input wire logic                 alertRequest,
    input wire logic [7:0]           alertMask,
    input wire vvc_pkg::vvc_margin_t marginSel,
    input wire logic [15:0]          vinOffThreshold,
    input wire logic [15:0]          activeTarget,
    input wire logic [15:0]          storeTarget,
    input wire logic [15:0]          storeCeiling,
    input wire logic [15:0]          storeMarginHigh,
    input wire logic [15:0]          storeMarginLow,
    input wire logic [15:0]          slewRate,
    input wire logic [15:0]          vinOnThreshold
);
    import vvc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // A write strobe carrying one command code
    sequence s_wr(logic [7:0] c);
        wrStrobe && cmdIn.code == c;
    endsequence
    // Format readback, read answers, rejected writes flagging the fault and keeping the stored value, alert gating and ceiling cap
    property p_fmt_rd; rdStrobe && cmdIn.code == 8'h20 |=> rdValid && rdData == 16'h0017; endproperty
    a_fmt_rd: assert property (p_fmt_rd) else $error("format readback wrong");
    property p_known; rdStrobe |=> rdValid == $past(cmdKnown); endproperty
    a_known: assert property (p_known) else $error("read answer ignores code");
    property p_fmt_wr; s_wr(8'h20) |=> invalidDataFault; endproperty
    a_fmt_wr: assert property (p_fmt_wr) else $error("format write accepted");
    property p_tgt; s_wr(8'h21) ##0 (!loadDefaults && (cmdIn.data < 16'h0100 ||
        cmdIn.data > 16'h0B00))
        |=> invalidDataFault && $stable(storeTarget); endproperty
    a_tgt: assert property (p_tgt) else $error("bad target kept");
    property p_ceil; s_wr(8'h24) ##0 (cmdIn.data < 16'h0100 || cmdIn.data > 16'h0B01)
        |=> invalidDataFault && $stable(storeCeiling); endproperty
    a_ceil: assert property (p_ceil) else $error("bad ceiling kept");
    property p_mhi; s_wr(8'h25) ##0 cmdIn.data <= storeMarginLow
        |=> invalidDataFault && $stable(storeMarginHigh); endproperty
    a_mhi: assert property (p_mhi) else $error("margin high accepted");
    property p_mlo; s_wr(8'h26) ##0 cmdIn.data >= storeMarginHigh
        |=> invalidDataFault && $stable(storeMarginLow); endproperty
    a_mlo: assert property (p_mlo) else $error("margin low accepted");
    property p_slew; s_wr(8'h27) ##0 !(cmdIn.data inside {16'hD00D, 16'hD07D, 16'hD0BB,
        16'hD258}) |=> invalidDataFault && $stable(slewRate); endproperty
    a_slew: assert property (p_slew) else $error("bad slew kept");
    property p_von; s_wr(8'h35) ##0 (cmdIn.data < 16'hF806 || cmdIn.data > 16'hF815 ||
        cmdIn.data <= vinOffThreshold) |=> invalidDataFault && $stable(vinOnThreshold); endproperty
    a_von: assert property (p_von) else $error("bad turn-on kept");
    property p_alert; alertRequest == |(statusIn & ~alertMask); endproperty
    a_alert: assert property (p_alert) else $error("alert mask ignored");
    property p_cap; $stable(storeCeiling) && $stable(storeTarget) && $stable(marginSel)
        |-> activeTarget <= storeCeiling; endproperty
    a_cap: assert property (p_cap) else $error("target above ceiling");
endmodule : vvc_bank_props
bind vvc_bank vvc_bank_props u_props (.*);

// ==== vvc_host_model.sv ====
// Host controller model: one whole command per strobe pulse.
// Assumes the bench clock; drives only on falling edges.
`timescale 1ns/100ps
module vvc_host_model (
    input  wire logic         clk,
    input  wire logic         rdValid,
    input  wire logic [15:0]  rdData,
    output logic              wrStrobe,
    output logic              rdStrobe,
    output vvc_pkg::vvc_cmd_t cmdIn
);
    import vvc_pkg::*;
    // Idle until the first request
    initial begin
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        cmdIn = '0;
    end
    // Held over one rising edge; idle bus flips so no stale value lingers
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk) cmdIn = '{c, d};
        wrStrobe = 1'b1;
        @(negedge clk) wrStrobe = 1'b0;
        cmdIn = ~cmdIn;
    endtask : wr
    // Answer taken in the cycle after the strobe
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
        @(negedge clk) cmdIn = '{c, 16'h0000};
        rdStrobe = 1'b1;
        @(negedge clk) rdStrobe = 1'b0;
        cmdIn = ~cmdIn;
        v = rdValid;
        d = rdData;
    endtask : rd
endmodule : vvc_host_model

// ==== vvc_bank_tb_top.sv ====
// Testbench for the command bank: host model drives, bench judges.
// Assumes read answers one cycle after the strobe, writes next edge.
`timescale 1ns/100ps
module vvc_bank_tb_top;
    import vvc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, faultClear = 1'b0, loadDefaults = 1'b0, outputOn = 1'b0;
    logic biasEnabled = 1'b0, vinAboveOn = 1'b0, wrStrobe, rdStrobe, rdValid, cmdKnown;
    logic invalidDataFault, alertRequest, vinUvFault, slewApply, v, s;
    logic [7:0] statusIn = 8'h40, vendorModeSetting = 8'h00, alertMask;
    logic [15:0] voltageSelectPin = 16'h0400, vinOffThreshold = 16'hF80A, rdData, q, p;
    logic [15:0] activeTarget, slewRate, loopScale, switchFreq, vinOnThreshold;
    logic [15:0] storeTarget, storeCeiling, storeMarginHigh, storeMarginLow;
    vvc_margin_t marginSel = MARGIN_OFF;
    vvc_cmd_t cmdIn;
    int failures = 0, check_count = 0;
    // Entries {accepted, code, data}; order matters, checks use stored peers
    logic [24:0] tbl [0:34] = '{25'h1210100, 25'h1210B00, 25'h02100FF, 25'h0210B01,
        25'h1240B01, 25'h0240B02, 25'h02400FF, 25'h1240B00,
        25'h0250667, 25'h1250668, 25'h12506CD, 25'h02606CD, 25'h12606CC, 25'h1260667,
        25'h127D07D, 25'h127D0BB, 25'h127D258, 25'h027D259, 25'h127D00D,
        25'h129F002, 25'h029F003, 25'h129F004, 25'h129F001,
        25'h1330864, 25'h1330B84, 25'h0330865, 25'h0330A71, 25'h133092C,
        25'h135F815, 25'h035F816, 25'h035F805, 25'h035F80A, 25'h135F80C,
        25'h11B0040, 25'h0200017};
    vvc_bank #(.UV_WAIT_CYCLES(20)) uut (.*);
    vvc_host_model host (.*);
    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // Write one entry, then judge fault flag and readback
    task automatic try(input logic [24:0] e);
        host.rd(e[23:16], p, v);
        @(negedge clk) faultClear = 1'b1;
        @(negedge clk) faultClear = 1'b0;
        host.wr(e[23:16], e[15:0]);
        chk("fault", 16'(invalidDataFault), 16'(!e[24]));
        host.rd(e[23:16], q, v);
        chk("readback", q, e[24] ? e[15:0] : p);
    endtask : try
    task automatic at(input vvc_margin_t m, input logic [15:0] e);
        @(negedge clk) marginSel = m;
        repeat (2) @(negedge clk);
        chk("active target", activeTarget, e);
    endtask : at
    task automatic seen4;
        s = 1'b0;
        repeat (4) @(negedge clk) s = s | slewApply;
    endtask : seen4
    task automatic t_defaults;
        chk("ceiling", storeCeiling, 16'h0B00);
        chk("margin high", storeMarginHigh, MARGIN_HIGH_RST);
        chk("margin low", storeMarginLow, MARGIN_LOW_RST);
        chk("slew", slewRate, 16'hD00D);
        chk("freq", switchFreq, 16'h092C);
        chk("turn-on", vinOnThreshold, 16'hF80C);
        host.rd(CMD_VOUT_FORMAT, q, v);
        chk("format", q, 16'h0017);
        chk("format valid", 16'(v), 16'h0001);
        host.rd(8'h22, q, v);
        chk("unknown valid", 16'(v), 16'h0000);
    endtask : t_defaults
    task automatic t_cap;
        chk("loop scale", loopScale, 16'hF001);
        host.wr(CMD_VOUT_CEILING, 16'h0400);
        at(MARGIN_HIGH, 16'h0400);
        host.wr(CMD_VOUT_CEILING, 16'h0B00);
        at(MARGIN_HIGH, 16'h06CD);
        at(MARGIN_LOW, 16'h0667);
        at(MARGIN_OFF, 16'h0B00);
        chk("alert masked", 16'(alertRequest), 16'h0000);
        host.wr(CMD_ALERT_MASK, 16'h0001);
        chk("alert open", 16'(alertRequest), 16'h0001);
    endtask : t_cap
    task automatic t_pin_slew;
        repeat (2) @(negedge clk) loadDefaults = !loadDefaults;
        chk("pin target", storeTarget, 16'h0400);
        vendorModeSetting = 8'h01;
        voltageSelectPin = 16'h0500;
        repeat (2) @(negedge clk) loadDefaults = !loadDefaults;
        chk("pin ignored", storeTarget, 16'h0400);
        host.wr(CMD_VOUT_TARGET, 16'h0600);
        seen4();
        chk("slew while off", 16'(s), 16'h0000);
        outputOn = 1'b1;
        seen4();
        chk("slew at turn-on", 16'(s), 16'h0000);
        host.wr(CMD_VOUT_TARGET, 16'h0500);
        seen4();
        chk("slew on change", 16'(s), 16'h0001);
    endtask : t_pin_slew
    task automatic t_uv;
        biasEnabled = 1'b1;
        repeat (10) @(negedge clk);
        chk("uv early", 16'(vinUvFault), 16'h0000);
        repeat (20) @(negedge clk);
        chk("uv late", 16'(vinUvFault), 16'h0001);
        rst = 1'b1;
        vinAboveOn = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (30) @(negedge clk);
        chk("uv reached", 16'(vinUvFault), 16'h0000);
        chk("target reset", storeTarget, TARGET_RST);
    endtask : t_uv
    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_defaults();
        foreach (tbl[i]) try(tbl[i]);
        t_cap();
        t_pin_slew();
        t_uv();
        wrap_up();
    end
    // Watchdog: run needs about 400 cycles
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule : vvc_bank_tb_top
